// ---- rtl/wses_top.v ----
// Purpose: wake event status, enables and active-low wake output
// Assumes: i_sys_rst is the standby-rail power-on reset
// Notes:   classic wishbone slave, one registered ack per access
//
// Function
// - the summary flag sets on each rising edge of the wake request, whatever the global enable.
// - writing one to the summary flag clears it and stops the wake drive; zero does nothing.
// - the summary flag resets only on the standby-rail power-on reset.
// - global enable bit 0 gates the wake output, blocked while zero.
// - the global enable resets to zero only on the standby-rail power-on reset.
// - unused bits 7 to 1 and all reserved bits read as zero.
// - each source status bit records activity regardless of any enable.
// - a source event sets its status bit, which holds until software clears it.
// - status bits clear individually by writing one; zero leaves them unchanged.
// - source status registers reset to zero only on the standby-rail power-on reset.
// - group one bits are pin a, pin b, ring one, keyboard, mouse, key, fan, ring two.
// - group two bits 0 to 7 are general pins 10 to 17.
// - group three bits 0 to 7 are general pins 20 to 27.
// - offsets 6D to 7F are reserved, read-only and read zero.
// - the parallel port irq reads one while the port is off, else follows ack.
// - a source drives wake only with its status, its enable and global enable set.
`timescale 1ns/1ps
`include "wses_defs.vh"

module wses_top #(
    parameter DW = 8
) (
    input  wire        i_clk_sys,
    input  wire        i_sys_rst,
    input  wire        i_wb_cyc,
    input  wire        i_wb_stb,
    input  wire        i_wb_we,
    input  wire [8:0]  i_wb_adr,
    input  wire [3:0]  i_wb_sel,
    input  wire [31:0] i_wb_dat,
    output reg  [31:0] o_wb_dat,
    output reg         o_wb_ack,
    input  wire        i_kbc_port_pin_a,
    input  wire        i_kbc_port_pin_b,
    input  wire        i_ring_indicate_one_n,
    input  wire        i_keyboard_wake,
    input  wire        i_mouse_wake,
    input  wire        i_specific_key_wake,
    input  wire        i_fan_speed_pulse_wake,
    input  wire        i_ring_indicate_two_n,
    input  wire [7:0]  i_general_pin_10,
    input  wire [7:0]  i_general_pin_20,
    input  wire        i_par_port_active,
    input  wire        i_printer_ack_n,
    input  wire [7:1]  i_aux_wake,
    output reg         o_wake_event_out_n,
    output reg         o_irq
);

    // ======================================================
    // bus decode
    wire [6:0]    idx;
    wire          acc;
    wire          wr;
    wire [DW-1:0] wdat;

    assign idx  = i_wb_adr[8:2];
    assign acc  = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    assign wr   = acc & i_wb_we & i_wb_sel[0];
    assign wdat = i_wb_dat[DW-1:0];

    // ======================================================
    // source inputs
    wire [DW-1:0] src_one;
    wire [DW-1:0] src_two;
    wire [DW-1:0] src_three;
    wire [DW-1:0] src_seven;
    wire          parallel_port_irq;

    assign src_one = {~i_ring_indicate_two_n,
                      i_fan_speed_pulse_wake,
                      i_specific_key_wake,
                      i_mouse_wake,
                      i_keyboard_wake,
                      ~i_ring_indicate_one_n,
                      i_kbc_port_pin_b,
                      i_kbc_port_pin_a};
    assign src_two   = i_general_pin_10;
    assign src_three = i_general_pin_20;
    assign parallel_port_irq = i_par_port_active ?
                               ~i_printer_ack_n : 1'b1;
    assign src_seven = {i_aux_wake, parallel_port_irq};

    // ======================================================
    // per-source status, sticky with write-one clear
    wire [DW-1:0] sts_one;
    wire [DW-1:0] sts_two;
    wire [DW-1:0] sts_three;
    wire [DW-1:0] sts_seven;
    wire [DW-1:0] clr_one;
    wire [DW-1:0] clr_two;
    wire [DW-1:0] clr_three;
    wire [DW-1:0] clr_seven;

    assign clr_one   = (wr && idx == `WSES_IDX_STS_ONE) ?
                       wdat : {DW{1'b0}};
    assign clr_two   = (wr && idx == `WSES_IDX_STS_TWO) ?
                       wdat : {DW{1'b0}};
    assign clr_three = (wr && idx == `WSES_IDX_STS_THREE) ?
                       wdat : {DW{1'b0}};
    assign clr_seven = (wr && idx == `WSES_IDX_STS_SEVEN) ?
                       wdat : {DW{1'b0}};

    // events set status whatever the enables
    wses_sticky #(.WIDTH(DW)) u_sts_one (
        .i_clk_sys (i_clk_sys),
        .i_sys_rst (i_sys_rst),
        .i_set     (src_one),
        .i_clr     (clr_one),
        .o_q       (sts_one)
    );

    wses_sticky #(.WIDTH(DW)) u_sts_two (
        .i_clk_sys (i_clk_sys),
        .i_sys_rst (i_sys_rst),
        .i_set     (src_two),
        .i_clr     (clr_two),
        .o_q       (sts_two)
    );

    wses_sticky #(.WIDTH(DW)) u_sts_three (
        .i_clk_sys (i_clk_sys),
        .i_sys_rst (i_sys_rst),
        .i_set     (src_three),
        .i_clr     (clr_three),
        .o_q       (sts_three)
    );

    wses_sticky #(.WIDTH(DW)) u_sts_seven (
        .i_clk_sys (i_clk_sys),
        .i_sys_rst (i_sys_rst),
        .i_set     (src_seven),
        .i_clr     (clr_seven),
        .o_q       (sts_seven)
    );

    // ======================================================
    // enable registers
    reg [DW-1:0] en_one_q;
    reg [DW-1:0] en_two_q;
    reg [DW-1:0] en_three_q;
    reg [DW-1:0] en_seven_q;
    reg          global_en_q;
    reg [1:0]    irq_en_q;

    always @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            en_one_q    <= `WSES_RST_BYTE;
            en_two_q    <= `WSES_RST_BYTE;
            en_three_q  <= `WSES_RST_BYTE;
            en_seven_q  <= `WSES_RST_BYTE;
            global_en_q <= 1'b0;
            irq_en_q    <= `WSES_RST_IRQ;
        end else if (wr) begin
            case (idx)
                `WSES_IDX_EN_ONE: begin
                    en_one_q <= wdat;
                end
                `WSES_IDX_EN_TWO: begin
                    en_two_q <= wdat;
                end
                `WSES_IDX_EN_THREE: begin
                    en_three_q <= wdat;
                end
                `WSES_IDX_EN_SEVEN: begin
                    en_seven_q <= wdat;
                end
                `WSES_IDX_GLOBAL_EN: begin
                    global_en_q <= wdat[`WSES_BIT_GLOBAL_EN];
                end
                `WSES_IDX_IRQ_EN: begin
                    irq_en_q <= wdat[1:0];
                end
                default: begin
                    en_one_q <= en_one_q;
                end
            endcase
        end
    end

    // ======================================================
    // wake request and summary flag
    wire wake_req;
    reg  wake_req_q;
    reg  summary_q;
    wire summary_set;
    wire summary_clr;

    assign wake_req = |(sts_one & en_one_q) |
                      |(sts_two & en_two_q) |
                      |(sts_three & en_three_q) |
                      |(sts_seven & en_seven_q);
    assign summary_set = wake_req & ~wake_req_q;
    assign summary_clr = wr && idx == `WSES_IDX_SUMMARY_STS &&
                         wdat[`WSES_BIT_SUMMARY_FLAG];

    always @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wake_req_q <= 1'b0;
            summary_q  <= 1'b0;
        end else begin
            wake_req_q <= wake_req;
            if (summary_set) begin
                summary_q <= 1'b1;
            end else if (summary_clr) begin
                summary_q <= 1'b0;
            end
        end
    end

    // active-low wake, gated by global enable and summary flag
    always @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_wake_event_out_n <= 1'b1;
        end else begin
            o_wake_event_out_n <= ~(global_en_q & summary_q &
                                    wake_req);
        end
    end

    // ======================================================
    // interrupt status, clear and enable
    wire [1:0] irq_sts;
    wire [1:0] irq_set;
    wire [1:0] irq_clr;

    assign irq_set = {|(src_one | src_two | src_three | src_seven),
                      summary_set};
    assign irq_clr = (wr && idx == `WSES_IDX_IRQ_CLR) ?
                     wdat[1:0] : 2'h0;

    wses_sticky #(.WIDTH(2)) u_irq_sts (
        .i_clk_sys (i_clk_sys),
        .i_sys_rst (i_sys_rst),
        .i_set     (irq_set),
        .i_clr     (irq_clr),
        .o_q       (irq_sts)
    );

    always @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(irq_sts & irq_en_q);
        end
    end

    // ======================================================
    // read mux
    reg [DW-1:0] rd_byte;

    always @* begin
        rd_byte = {DW{1'b0}};
        case (idx)
            `WSES_IDX_SUMMARY_STS: begin
                rd_byte[`WSES_BIT_SUMMARY_FLAG] = summary_q;
            end
            `WSES_IDX_GLOBAL_EN: begin
                rd_byte[`WSES_BIT_GLOBAL_EN] = global_en_q;
            end
            `WSES_IDX_STS_ONE: begin
                rd_byte = sts_one;
            end
            `WSES_IDX_STS_TWO: begin
                rd_byte = sts_two;
            end
            `WSES_IDX_STS_THREE: begin
                rd_byte = sts_three;
            end
            `WSES_IDX_STS_SEVEN: begin
                rd_byte = sts_seven;
            end
            `WSES_IDX_EN_ONE: begin
                rd_byte = en_one_q;
            end
            `WSES_IDX_EN_TWO: begin
                rd_byte = en_two_q;
            end
            `WSES_IDX_EN_THREE: begin
                rd_byte = en_three_q;
            end
            `WSES_IDX_EN_SEVEN: begin
                rd_byte = en_seven_q;
            end
            `WSES_IDX_IRQ_STS: begin
                rd_byte[1:0] = irq_sts;
            end
            `WSES_IDX_IRQ_EN: begin
                rd_byte[1:0] = irq_en_q;
            end
            default: begin
                rd_byte = {DW{1'b0}};
            end
        endcase
    end

    // ======================================================
    // ack and read data, one cycle after the request
    always @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= `WSES_RST_WORD;
        end else begin
            o_wb_ack <= acc;
            if (acc && !i_wb_we) begin
                o_wb_dat <= {{(32-DW){1'b0}}, rd_byte};
            end
        end
    end

endmodule // wses_top

// ---- common/wses_defs.vh ----
// Purpose: constants of the wake event status and enable block
// Assumes: register index = printed offset, byte address = 4 * index
// Notes:   definitions only
`ifndef WSES_DEFS_VH
`define WSES_DEFS_VH

// ==========================================================
// register indices
`define WSES_IDX_SUMMARY_STS  7'h00
`define WSES_IDX_GLOBAL_EN    7'h02
`define WSES_IDX_STS_ONE      7'h04
`define WSES_IDX_STS_TWO      7'h05
`define WSES_IDX_STS_THREE    7'h06
`define WSES_IDX_EN_ONE       7'h0A
`define WSES_IDX_EN_TWO       7'h0B
`define WSES_IDX_EN_THREE     7'h0C
`define WSES_IDX_IRQ_STS      7'h10
`define WSES_IDX_IRQ_CLR      7'h11
`define WSES_IDX_IRQ_EN       7'h12
`define WSES_IDX_STS_SEVEN    7'h68
`define WSES_IDX_EN_SEVEN     7'h6C
`define WSES_IDX_RSVD_FIRST   7'h6D

// ==========================================================
// field positions
`define WSES_BIT_SUMMARY_FLAG 0
`define WSES_BIT_GLOBAL_EN    0
`define WSES_BIT_IRQ_SUMMARY  0
`define WSES_BIT_IRQ_SOURCE   1
`define WSES_BIT_PAR_IRQ      0

// ==========================================================
// reset values
`define WSES_RST_BYTE         8'h00
`define WSES_RST_IRQ          2'h0
`define WSES_RST_WORD         32'h0000_0000

`endif

// ---- rtl/wses_sticky.v ----
// Purpose: sticky status bits, set by events, cleared by writing one
// Assumes: clear is a single-cycle qualified strobe; set may be a held level
// Notes:   a set in the clearing cycle wins
`timescale 1ns/1ps

module wses_sticky #(
    parameter WIDTH = 8
) (
    input  wire             i_clk_sys,
    input  wire             i_sys_rst,
    input  wire [WIDTH-1:0] i_set,
    input  wire [WIDTH-1:0] i_clr,
    output wire [WIDTH-1:0] o_q
);

    // ======================================================
    // one flag per bit
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            reg flag_q;
            always @(posedge i_clk_sys or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    flag_q <= 1'b0;
                end else if (i_set[g]) begin
                    flag_q <= 1'b1;
                end else if (i_clr[g]) begin
                    flag_q <= 1'b0;
                end
            end
            assign o_q[g] = flag_q;
        end
    endgenerate

endmodule // wses_sticky

// ---- dv/wses_properties.sv ----
// Purpose: port checks of wses_top
// Assumes: one clock domain, async reset
// Notes:   bound to every wses_top
`timescale 1ns/1ps
module wses_props (
    input wire        i_clk_sys,
    input wire        i_sys_rst,
    input wire        i_wb_cyc,
    input wire        i_wb_stb,
    input wire        i_wb_we,
    input wire [8:0]  i_wb_adr,
    input wire [3:0]  i_wb_sel,
    input wire [31:0] i_wb_dat,
    input wire [31:0] o_wb_dat,
    input wire        o_wb_ack,
    input wire        o_wake_event_out_n,
    input wire        o_irq
);
// ========================================
// helpers
default clocking dc @(posedge i_clk_sys); endclocking
default disable iff (i_sys_rst);
wire       tk = i_wb_cyc && i_wb_stb && !o_wb_ack;
wire       wr = tk && i_wb_we && i_wb_sel[0];
wire [6:0] ix = i_wb_adr[8:2];
// ========================================
// properties
property p_ack_one; o_wb_ack |=> !o_wb_ack; endproperty
a_ack_one: assert property (p_ack_one) else $error("ack too long");
property p_ack_req; tk |=> o_wb_ack; endproperty
a_ack_req: assert property (p_ack_req) else $error("no ack");
property p_ack_idle; !(i_wb_cyc && i_wb_stb) |=> !o_wb_ack; endproperty
a_ack_idle: assert property (p_ack_idle) else $error("stray ack");
property p_dat_hi; o_wb_ack |-> o_wb_dat[31:8] == 24'h000000; endproperty
a_dat_hi: assert property (p_dat_hi) else $error("upper data set");
property p_unused;
    tk && !i_wb_we && (ix == 7'h00 || ix == 7'h02) |=> o_wb_dat[7:1] == 7'h00;
endproperty
a_unused: assert property (p_unused) else $error("unused bits");
property p_rsvd; tk && !i_wb_we && ix >= 7'h6D |=> o_wb_dat == 32'h0; endproperty
a_rsvd: assert property (p_rsvd) else $error("reserved read");
property p_gen_off;
    wr && ix == 7'h02 && !i_wb_dat[0] |=> ##1 o_wake_event_out_n;
endproperty
a_gen_off: assert property (p_gen_off) else $error("wake not gated");
property p_sum_clr;
    wr && ix == 7'h00 && i_wb_dat[0] |=> ##1 o_wake_event_out_n;
endproperty
a_sum_clr: assert property (p_sum_clr) else $error("wake after clear");
c_wake: cover property ($fell(o_wake_event_out_n));
c_irq: cover property ($rose(o_irq));
c_rsvd: cover property (tk && ix >= 7'h6D);
endmodule // wses_props
bind wses_top wses_props u_props (.*);

// ---- dv/wses_host_model.sv ----
// Purpose: host side wake input, counts wake assertions
// Assumes: wake line is active low level
// Notes:   counts falling edges only
`timescale 1ns/1ps
module wses_host_model (
    input  wire       i_clk_sys,
    input  wire       i_sys_rst,
    input  wire       i_wake_n,
    output reg  [7:0] o_wake_cnt
);
reg wake_q;
always @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
        wake_q <= 1'h1;
        o_wake_cnt <= 8'h00;
    end else begin
        wake_q <= i_wake_n;
        if (wake_q && !i_wake_n)
            o_wake_cnt <= o_wake_cnt + 8'h01;
    end
end
endmodule // wses_host_model

// ---- dv/tb_top.sv ----
// Purpose: scenario bench of wses_top
// Assumes: 40 MHz clock, reset held 3 cycles
// Notes:   host model counts wake assertions
`timescale 1ns/1ps
module tb_top;
// ========================================
// signals
reg         clk = 1'h0;
reg         rst = 1'h1;
reg         cyc = 1'h0, stb = 1'h0, we = 1'h0, pa = 1'h1, ackn = 1'h1;
reg  [8:0]  adr = 9'h000;
reg  [31:0] wd = 32'h0;
reg  [23:0] src = 24'h0;
reg  [7:1]  aux = 7'h00;
reg  [7:0]  r, b;
reg  [6:0]  x;
wire [31:0] rdat;
wire        ack, wake_n, irq;
wire [7:0]  cnt;
integer     fail_count = 0, n_checks = 0, i;
logic [6:0] rt [10] = '{7'h00, 7'h02, 7'h04, 7'h05, 7'h06,
                        7'h0A, 7'h0C, 7'h68, 7'h6C, 7'h12};
initial forever #12.5 clk = ~clk;
wses_top u_dut (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wd),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_kbc_port_pin_a(src[0]),
    .i_kbc_port_pin_b(src[1]), .i_ring_indicate_one_n(~src[2]),
    .i_keyboard_wake(src[3]), .i_mouse_wake(src[4]),
    .i_specific_key_wake(src[5]), .i_fan_speed_pulse_wake(src[6]),
    .i_ring_indicate_two_n(~src[7]), .i_general_pin_10(src[15:8]),
    .i_general_pin_20(src[23:16]), .i_par_port_active(pa),
    .i_printer_ack_n(ackn), .i_aux_wake(aux),
    .o_wake_event_out_n(wake_n), .o_irq(irq));
wses_host_model u_host (.i_clk_sys(clk), .i_sys_rst(rst),
    .i_wake_n(wake_n), .o_wake_cnt(cnt));
// ========================================
// shared tasks
task print_verdict;
    begin
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
endtask
task chk(input string nm, input [7:0] e, input [7:0] g);
    begin
        n_checks = n_checks + 1;
        if (g !== e) begin
            fail_count = fail_count + 1;
            $display("[ERR] %0s exp %h got %h", nm, e, g);
        end
    end
endtask
task bus(input w, input [6:0] ix, input [7:0] d);
    begin
        @(posedge clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= {ix, 2'h0};
        wd <= {24'h0, d};
        @(posedge clk);
        // only the watchdog ends a wait for ack
        while (ack !== 1'h1) @(posedge clk);
        r = rdat[7:0];
        cyc <= 1'h0;
        stb <= 1'h0;
    end
endtask
task rdc(input [6:0] ix, input [7:0] e);
    begin
        bus(1'h0, ix, 8'h00);
        chk("register", e, r);
    end
endtask
task wt(input s, input e);
    integer n;
    begin
        for (n = 0; n < 10 && (s ? irq : wake_n) !== e; n = n + 1)
            @(posedge clk);
        chk(s ? "irq" : "wake", {7'h00, e}, {7'h00, s ? irq : wake_n});
    end
endtask
task pulse(input [23:0] v);
    begin
        @(posedge clk) src <= v;
        @(posedge clk) src <= 24'h0;
    end
endtask
// ========================================
// scenarios
task t_reset;
    begin
        for (i = 0; i < 10; i = i + 1) rdc(rt[i], 8'h00);
        wt(1'h0, 1'h1);
    end
endtask
task t_scan;
    begin
        for (i = 0; i < 24; i = i + 1) begin
            x = 7'h04 + i / 8;
            b = 8'h01 << i % 8;
            pulse(24'h1 << i);
            rdc(x, b);
            bus(1'h1, x, 8'h00);
            rdc(x, b);
            bus(1'h1, x, b);
            rdc(x, 8'h00);
        end
        pulse(24'h000001);
        bus(1'h1, 7'h02, 8'h01);
        @(posedge clk) rst <= 1'h1;
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        rdc(7'h04, 8'h00);
        rdc(7'h02, 8'h00);
    end
endtask
task t_wake;
    begin
        bus(1'h1, 7'h0A, 8'h08);
        pulse(24'h000008);
        repeat (4) @(posedge clk);
        wt(1'h0, 1'h1);
        rdc(7'h00, 8'h01);
        bus(1'h1, 7'h02, 8'h01);
        wt(1'h0, 1'h0);
        bus(1'h1, 7'h02, 8'h00);
        wt(1'h0, 1'h1);
        bus(1'h1, 7'h02, 8'hFF);
        rdc(7'h02, 8'h01);
        wt(1'h0, 1'h0);
        bus(1'h1, 7'h00, 8'h00);
        rdc(7'h00, 8'h01);
        bus(1'h1, 7'h00, 8'h01);
        wt(1'h0, 1'h1);
        rdc(7'h00, 8'h00);
        chk("wake count", 8'h02, cnt);
        bus(1'h1, 7'h04, 8'h08);
        bus(1'h1, 7'h0A, 8'h00);
        pulse(24'h000010);
        repeat (4) @(posedge clk);
        wt(1'h0, 1'h1);
        rdc(7'h04, 8'h10);
        bus(1'h1, 7'h04, 8'h10);
    end
endtask
task t_par;
    begin
        pa <= 1'h0;
        repeat (3) @(posedge clk);
        bus(1'h1, 7'h68, 8'h01);
        rdc(7'h68, 8'h01);
        pa <= 1'h1;
        bus(1'h1, 7'h68, 8'h01);
        rdc(7'h68, 8'h00);
        ackn <= 1'h0;
        rdc(7'h68, 8'h01);
        ackn <= 1'h1;
        @(posedge clk) aux <= 7'h40;
        @(posedge clk) aux <= 7'h00;
        bus(1'h1, 7'h68, 8'h01);
        rdc(7'h68, 8'h80);
        bus(1'h1, 7'h68, 8'h80);
        bus(1'h1, 7'h6C, 8'hFF);
        rdc(7'h6C, 8'hFF);
        bus(1'h1, 7'h6C, 8'h00);
    end
endtask
task t_irq;
    begin
        bus(1'h1, 7'h11, 8'h03);
        rdc(7'h10, 8'h00);
        bus(1'h1, 7'h12, 8'h02);
        pulse(24'h000100);
        wt(1'h1, 1'h1);
        bus(1'h1, 7'h12, 8'h00);
        wt(1'h1, 1'h0);
        bus(1'h1, 7'h12, 8'h02);
        wt(1'h1, 1'h1);
        bus(1'h1, 7'h11, 8'h03);
        wt(1'h1, 1'h0);
        rdc(7'h10, 8'h00);
        bus(1'h1, 7'h05, 8'h01);
        // summary-set interrupt, with the wake output still enabled
        bus(1'h1, 7'h12, 8'h01);
        bus(1'h1, 7'h0A, 8'h08);
        pulse(24'h000008);
        wt(1'h1, 1'h1);
        rdc(7'h10, 8'h03);
        bus(1'h1, 7'h04, 8'h08);
        bus(1'h1, 7'h0A, 8'h00);
        bus(1'h1, 7'h11, 8'h03);
        bus(1'h1, 7'h00, 8'h01);
        wt(1'h1, 1'h0);
        wt(1'h0, 1'h1);
    end
endtask
task t_rsvd;
    begin
        for (i = 0; i < 3; i = i + 1) begin
            x = (i == 0) ? 7'h6D : (i == 1) ? 7'h7F : 7'h01;
            bus(1'h1, x, 8'hFF);
            rdc(x, 8'h00);
        end
    end
endtask
// ========================================
// main and watchdog
initial begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    t_reset;
    t_scan;
    t_wake;
    t_par;
    t_irq;
    t_rsvd;
    print_verdict;
end
initial begin
    repeat (20000) @(posedge clk);
    fail_count = fail_count + 1;
    print_verdict;
end
endmodule // tb_top
